// ### src/svr_pkg.sv
// Constants, field positions and register offsets of the vector register file
package svr_pkg;
  localparam int NUM_REGS = 32;
  localparam int IDX_W = 5;
  localparam int REG_W = 128;
  localparam int BYTES = 16;
  localparam int ELEM_W = 4;
  localparam int DW_W = 64;
  localparam int WORD_W = 32;

  // Element format codes: log2 of bytes per element
  localparam logic [1:0] FMT_BYTE = 2'h0;
  localparam logic [1:0] FMT_HALF = 2'h1;
  localparam logic [1:0] FMT_WORD = 2'h2;
  localparam logic [1:0] FMT_DOUBLE = 2'h3;

  // Avalon-MM register map, byte addresses
  localparam int AVS_AW = 5;
  localparam logic [4:0] OFS_CONFIG_WORD_ZERO = 5'h00;
  localparam logic [4:0] OFS_CONFIG_WORD_THREE = 5'h04;
  localparam logic [4:0] OFS_CONFIG_WORD_FIVE = 5'h08;
  localparam logic [4:0] OFS_FPU_MODE = 5'h0c;
  localparam logic [4:0] OFS_GATE_STATUS = 5'h10;

  // Field positions
  localparam int BIT_BIG_ENDIAN = 15;
  localparam int BIT_IMPL_PRESENT = 28;
  localparam int BIT_UNIT_ENABLE = 27;
  localparam int BIT_FPU_USABLE = 29;
  localparam int BIT_FPU_WIDE = 26;
  localparam int BIT_LAST_RESERVED = 0;
  localparam int BIT_LAST_DISABLED = 1;
  localparam int BIT_SEEN_RESERVED = 2;
  localparam int BIT_SEEN_DISABLED = 3;

  // Reset values
  localparam logic RST_BIG_ENDIAN = 1'b0;
  localparam logic RST_UNIT_ENABLE = 1'b0;
  localparam logic RST_FPU_USABLE = 1'b0;
  localparam logic RST_FPU_WIDE = 1'b1;
endpackage : svr_pkg

// ### src/svr_vector_regfile.sv
// SIMD vector register file with FPU aliasing, gating and Avalon-MM config
// Notes on behaviour
// - 32 vector registers, 128 bits, 5-bit index
// - Byte, halfword, word, doubleword element views
// - Element 0 at bit 0, last ends bit 127
// - Element n occupies bits n*w+w-1 to n*w
// - FPU registers share low part of vectors
// - FPU register r aliases element 0 of r
// - Only 64-bit FPU registers are supported
// - Implementation-present bit 28, read-only, hard-wired
// - Missing unit raises reserved instruction
// - Enable bit 27 clear raises vector-disabled
// - Enable bit resets to zero
// - Slide view has bytes-per-element rows
// - Slide rows are consecutive slices, row 0 lowest
// - Element 0 at lowest memory address
// - Element byte order follows endian bit 15
// - Word byte j at 4i+j or 4i+3-j
// - Compares write all-zero or all-one elements
// - One context; architectural index maps 1:1 to physical register
// - High-half FPU read returns word element 1
// - High-half FPU write keeps word element 0
// - FPU usable without wide mode raises reserved
`timescale 1ns/1ps
module svr_vector_regfile #(
  parameter bit UNIT_PRESENT = 1'b1,
  parameter bit FPU_PRESENT = 1'b1
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [svr_pkg::AVS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic dec_valid,
  output logic exc_reserved,
  output logic exc_disabled,
  output logic dec_accept,
  input wire logic vw_en,
  input wire logic vw_full,
  input wire logic [svr_pkg::IDX_W-1:0] vw_idx,
  input wire logic [1:0] vw_fmt,
  input wire logic [svr_pkg::ELEM_W-1:0] vw_elem,
  input wire logic [svr_pkg::REG_W-1:0] vw_data,
  input wire logic cmp_en,
  input wire logic [svr_pkg::IDX_W-1:0] cmp_idx,
  input wire logic [1:0] cmp_fmt,
  input wire logic [svr_pkg::BYTES-1:0] cmp_result,
  input wire logic ld_en,
  input wire logic [svr_pkg::IDX_W-1:0] ld_idx,
  input wire logic [1:0] ld_fmt,
  input wire logic [svr_pkg::REG_W-1:0] ld_data,
  input wire logic fpu_wr_en,
  input wire logic fpu_wr_hi,
  input wire logic fpu_wr_dbl,
  input wire logic [svr_pkg::IDX_W-1:0] fpu_wr_idx,
  input wire logic [svr_pkg::DW_W-1:0] fpu_wr_data,
  input wire logic [svr_pkg::IDX_W-1:0] vr_idx,
  input wire logic [1:0] vr_fmt,
  input wire logic [svr_pkg::ELEM_W-1:0] vr_elem,
  output logic [svr_pkg::REG_W-1:0] vr_data,
  output logic [svr_pkg::DW_W-1:0] vr_elem_data,
  input wire logic [svr_pkg::IDX_W-1:0] sl_idx,
  input wire logic [1:0] sl_fmt,
  input wire logic [2:0] sl_row,
  output logic [svr_pkg::REG_W-1:0] sl_row_data,
  input wire logic [svr_pkg::IDX_W-1:0] st_idx,
  input wire logic [1:0] st_fmt,
  output logic [svr_pkg::REG_W-1:0] st_data,
  input wire logic [svr_pkg::IDX_W-1:0] fpu_rd_idx,
  input wire logic fpu_rd_hi,
  input wire logic fpu_rd_dbl,
  output logic [svr_pkg::DW_W-1:0] fpu_rd_data
);
  import svr_pkg::*;

  // Storage; one context, so architectural index maps 1:1 to physical
  logic [REG_W-1:0] vreg_q [0:NUM_REGS-1];

  logic big_endian_q;
  logic unit_enable_q;
  logic fpu_usable_q;
  logic fpu_wide_q;
  logic last_res_q;
  logic last_dis_q;
  logic seen_res_q;
  logic seen_dis_q;
  logic waitreq_q;
  logic [31:0] rdata_q;
  logic exc_res_q;
  logic exc_dis_q;
  logic accept_q;
  logic [REG_W-1:0] vr_data_q;
  logic [DW_W-1:0] vr_elem_q;
  logic [REG_W-1:0] sl_row_q;
  logic [REG_W-1:0] st_data_q;
  logic [DW_W-1:0] fpu_rd_q;

  // Byte swap inside each element; it is its own inverse, so the same
  // function serves loads and stores.
  function automatic logic [REG_W-1:0] mem_order(
    input logic [REG_W-1:0] d,
    input logic [1:0] fmt,
    input logic be
  );
    logic [REG_W-1:0] r;
    int w;
    int src;
    r = '0;
    w = 1 << fmt;
    for (int k = 0; k < BYTES; k++)
    begin
      src = be ? ((k / w) * w + (w - 1 - (k % w))) : k;
      r[k*8 +: 8] = d[src*8 +: 8];
    end
    return r;
  endfunction : mem_order

  // Bit offset of element e in format f, element index masked to range
  function automatic logic [6:0] elem_shift(
    input logic [1:0] fmt,
    input logic [ELEM_W-1:0] e
  );
    logic [ELEM_W-1:0] em;
    em = e & (4'hf >> fmt);
    return 7'(em) << (3'(fmt) + 3'h3);
  endfunction : elem_shift

  function automatic logic [REG_W-1:0] width_mask(input logic [1:0] fmt);
    return {REG_W{1'b1}} >> (REG_W - (8 << fmt));
  endfunction : width_mask

  // Gating
  logic gate_reserved;
  logic gate_disabled;
  always_comb
  begin
    gate_reserved = !UNIT_PRESENT
      || (FPU_PRESENT && fpu_usable_q && !fpu_wide_q);
    gate_disabled = !gate_reserved && !unit_enable_q;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      exc_res_q <= 1'b0;
      exc_dis_q <= 1'b0;
      accept_q <= 1'b0;
    end
    else
    begin
      exc_res_q <= dec_valid && gate_reserved;
      exc_dis_q <= dec_valid && gate_disabled;
      accept_q <= dec_valid && !gate_reserved && !gate_disabled;
    end
  end

  // Software view of gate history; hardware set wins over a clear
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      last_res_q <= 1'b0;
      last_dis_q <= 1'b0;
      seen_res_q <= 1'b0;
      seen_dis_q <= 1'b0;
    end
    else
    begin
      if (dec_valid)
      begin
        last_res_q <= gate_reserved;
        last_dis_q <= gate_disabled;
      end
      if (avs_write && waitreq_q && avs_address == OFS_GATE_STATUS)
      begin
        if (avs_writedata[BIT_SEEN_RESERVED])
          seen_res_q <= 1'b0;
        if (avs_writedata[BIT_SEEN_DISABLED])
          seen_dis_q <= 1'b0;
      end
      if (dec_valid && gate_reserved)
        seen_res_q <= 1'b1;
      if (dec_valid && gate_disabled)
        seen_dis_q <= 1'b1;
    end
  end

  // Write source select: load, vector write, compare, FPU alias
  logic w_en;
  logic [IDX_W-1:0] w_idx;
  logic [BYTES-1:0] w_be;
  logic [REG_W-1:0] w_data;
  logic [REG_W-1:0] w_mask;
  logic [BYTES-1:0] vw_lanes;
  logic [BYTES-1:0] cmp_lanes;

  genvar b;
  generate
    for (b = 0; b < BYTES; b++)
    begin : g_lane
      assign vw_lanes[b] = (4'(b) >> vw_fmt) == (vw_elem & (4'hf >> vw_fmt));
      assign cmp_lanes[b] = cmp_result[4'(b) >> cmp_fmt];
      assign w_mask[b*8 +: 8] = {8{w_be[b]}};
    end
  endgenerate

  always_comb
  begin
    w_en = 1'b0;
    w_idx = '0;
    w_be = '0;
    w_data = '0;
    if (ld_en)
    begin
      w_en = 1'b1;
      w_idx = ld_idx;
      w_be = '1;
      w_data = mem_order(ld_data, ld_fmt, big_endian_q);
    end
    else if (vw_en)
    begin
      w_en = 1'b1;
      w_idx = vw_idx;
      w_be = vw_full ? '1 : vw_lanes;
      w_data = vw_full ? vw_data :
        (vw_data & width_mask(vw_fmt)) << elem_shift(vw_fmt, vw_elem);
    end
    else if (cmp_en)
    begin
      w_en = 1'b1;
      w_idx = cmp_idx;
      w_be = '1;
      for (int k = 0; k < BYTES; k++)
        w_data[k*8 +: 8] = {8{cmp_lanes[k]}};
    end
    else if (fpu_wr_en && FPU_PRESENT)
    begin
      w_en = 1'b1;
      w_idx = fpu_wr_idx;
      if (fpu_wr_hi)
      begin
        // Word element 0 and upper half kept
        w_en = fpu_wide_q;
        w_be = 16'h00f0;
        w_data = {64'h0, fpu_wr_data[WORD_W-1:0], 32'h0};
      end
      else
      begin
        // Whole 64-bit FPU register lives in the low half
        w_be = fpu_wr_dbl ? 16'h00ff : 16'h000f;
        w_data = {64'h0, fpu_wr_data};
      end
    end
  end

  // Unwritten lanes hold their value within the single update cycle
  always_ff @(posedge clock)
  begin
    if (w_en)
      vreg_q[w_idx] <= (vreg_q[w_idx] & ~w_mask) | (w_data & w_mask);
  end

  // Read ports, one cycle latency
  logic [REG_W-1:0] vr_word;
  logic [REG_W-1:0] sl_word;
  logic [REG_W-1:0] fpu_word;
  always_comb
  begin
    vr_word = vreg_q[vr_idx];
    sl_word = vreg_q[sl_idx];
    fpu_word = vreg_q[fpu_rd_idx];
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      vr_data_q <= '0;
      vr_elem_q <= '0;
      sl_row_q <= '0;
      st_data_q <= '0;
      fpu_rd_q <= '0;
    end
    else
    begin
      vr_data_q <= vr_word;
      vr_elem_q <= DW_W'((vr_word >> elem_shift(vr_fmt, vr_elem))
        & width_mask(vr_fmt));
      // Rows = bytes per element; row width = 128 bits / rows
      sl_row_q <= (sl_word >> (7'(sl_row & (3'h7 >> (2'h3 - sl_fmt)))
        << (3'h7 - 3'(sl_fmt))))
        & ~({REG_W{1'b1}} << (REG_W >> sl_fmt));
      st_data_q <= mem_order(vreg_q[st_idx], st_fmt, big_endian_q);
      if (fpu_rd_hi)
        fpu_rd_q <= {32'h0, fpu_word[2*WORD_W-1:WORD_W]};
      else if (fpu_rd_dbl)
        fpu_rd_q <= fpu_word[DW_W-1:0];
      else
        fpu_rd_q <= {32'h0, fpu_word[WORD_W-1:0]};
    end
  end

  // Avalon-MM slave: a request is answered with waitrequest low for one
  // cycle, one edge after it is seen.
  logic avs_take;
  assign avs_take = (avs_read || avs_write) && waitreq_q;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      waitreq_q <= 1'b1;
    else
      waitreq_q <= !avs_take;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      big_endian_q <= RST_BIG_ENDIAN;
      unit_enable_q <= RST_UNIT_ENABLE;
      fpu_usable_q <= RST_FPU_USABLE;
      fpu_wide_q <= RST_FPU_WIDE;
    end
    else if (avs_take && avs_write)
    begin
      case (avs_address)
        OFS_CONFIG_WORD_ZERO:
          big_endian_q <= avs_writedata[BIT_BIG_ENDIAN];
        OFS_CONFIG_WORD_FIVE:
          unit_enable_q <= avs_writedata[BIT_UNIT_ENABLE];
        OFS_FPU_MODE:
        begin
          fpu_usable_q <= avs_writedata[BIT_FPU_USABLE];
          fpu_wide_q <= avs_writedata[BIT_FPU_WIDE];
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      rdata_q <= '0;
    else if (avs_take && avs_read)
    begin
      rdata_q <= '0;
      case (avs_address)
        OFS_CONFIG_WORD_ZERO:
          rdata_q[BIT_BIG_ENDIAN] <= big_endian_q;
        OFS_CONFIG_WORD_THREE:
          rdata_q[BIT_IMPL_PRESENT] <= UNIT_PRESENT;
        OFS_CONFIG_WORD_FIVE:
          rdata_q[BIT_UNIT_ENABLE] <= unit_enable_q;
        OFS_FPU_MODE:
        begin
          rdata_q[BIT_FPU_USABLE] <= fpu_usable_q;
          rdata_q[BIT_FPU_WIDE] <= fpu_wide_q;
        end
        OFS_GATE_STATUS:
        begin
          rdata_q[BIT_LAST_RESERVED] <= last_res_q;
          rdata_q[BIT_LAST_DISABLED] <= last_dis_q;
          rdata_q[BIT_SEEN_RESERVED] <= seen_res_q;
          rdata_q[BIT_SEEN_DISABLED] <= seen_dis_q;
        end
        default:
          rdata_q <= '0;
      endcase
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = waitreq_q;
  assign exc_reserved = exc_res_q;
  assign exc_disabled = exc_dis_q;
  assign dec_accept = accept_q;
  assign vr_data = vr_data_q;
  assign vr_elem_data = vr_elem_q;
  assign sl_row_data = sl_row_q;
  assign st_data = st_data_q;
  assign fpu_rd_data = fpu_rd_q;
endmodule : svr_vector_regfile

// ### dv/svr_vector_regfile_assertions.sv
// Bus and decode checks on the vector register file ports
`timescale 1ns/1ps
module svr_vector_regfile_assertions
  import svr_pkg::*;
#(
  parameter bit UNIT_PRESENT = 1'b1,
  parameter bit FPU_PRESENT = 1'b1
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [svr_pkg::AVS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic dec_valid,
  input wire logic exc_reserved,
  input wire logic exc_disabled,
  input wire logic dec_accept
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic en_q, us_q, wd_q, res;
  wire wr_tk = avs_write && avs_waitrequest;
  assign res = !UNIT_PRESENT || (FPU_PRESENT && us_q && !wd_q);
  // Shadow of the gating bits, updated where the write is taken
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      en_q <= 1'b0;
      us_q <= RST_FPU_USABLE;
      wd_q <= RST_FPU_WIDE;
    end
    else if (wr_tk && avs_address == OFS_CONFIG_WORD_FIVE)
      en_q <= avs_writedata[BIT_UNIT_ENABLE];
    else if (wr_tk && avs_address == OFS_FPU_MODE)
    begin
      us_q <= avs_writedata[BIT_FPU_USABLE];
      wd_q <= avs_writedata[BIT_FPU_WIDE];
    end
  end
  sequence s_rd(logic [4:0] a);
    avs_read && avs_waitrequest && avs_address == a;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_wait_answer: assert property ((avs_read || avs_write) &&
    avs_waitrequest |=> s_answer) else $error("bus answer late");
  a_present_bit: assert property (s_rd(OFS_CONFIG_WORD_THREE) |=>
    avs_readdata[BIT_IMPL_PRESENT] == UNIT_PRESENT)
    else $error("present bit wrong");
  a_enable_bit: assert property (s_rd(OFS_CONFIG_WORD_FIVE) |=>
    avs_readdata[BIT_UNIT_ENABLE] == en_q) else $error("enable bit wrong");
  a_dec_reserved: assert property (dec_valid && res |=>
    exc_reserved && !exc_disabled) else $error("reserved missing");
  a_dec_disabled: assert property (dec_valid && !res && !en_q |=>
    exc_disabled && !dec_accept) else $error("disabled missing");
  a_dec_accept: assert property (dec_valid && !res && en_q |=>
    dec_accept && !exc_reserved) else $error("accept missing");
  a_one_answer: assert property (dec_valid |=>
    $onehot({exc_reserved, exc_disabled, dec_accept}))
    else $error("decode answer not single");
  a_no_answer: assert property (!dec_valid |=>
    !(exc_reserved || exc_disabled || dec_accept))
    else $error("answer without decode");
endmodule : svr_vector_regfile_assertions

bind svr_vector_regfile svr_vector_regfile_assertions #(
  .UNIT_PRESENT(UNIT_PRESENT),
  .FPU_PRESENT(FPU_PRESENT)
) i_svr_vector_regfile_assertions (
  .clock(clock),
  .rst_b(rst_b),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .dec_valid(dec_valid),
  .exc_reserved(exc_reserved),
  .exc_disabled(exc_disabled),
  .dec_accept(dec_accept)
);

// ### dv/svr_core_model.sv
// Core-side decode partner: issues one decode, records the answer
`timescale 1ns/1ps
module svr_core_model (
  input wire logic clock,
  input wire logic go,
  output logic dec_valid = 1'b0,
  input wire logic exc_reserved,
  input wire logic exc_disabled,
  input wire logic dec_accept,
  output logic [2:0] resp
);
  logic seen_q = 1'b0;
  // The answer stands one cycle only, so it is caught at that edge
  always @(posedge clock)
  begin
    dec_valid <= go;
    seen_q <= dec_valid;
    if (seen_q)
      resp <= {exc_reserved, exc_disabled, dec_accept};
  end
endmodule : svr_core_model

// ### dv/testbench.sv
// Self-checking bench for the vector register file
`timescale 1ns/1ps
module testbench;
  import svr_pkg::*;
  logic clock = 1'b0, rst_b = 1'b0, go = 1'b0;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [4:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, q;
  logic avs_waitrequest, dec_valid, exc_reserved, exc_disabled, dec_accept;
  logic vw_en = 1'b0, vw_full = 1'b0, cmp_en = 1'b0, ld_en = 1'b0;
  logic fpu_wr_en = 1'b0, fpu_wr_hi = 1'b0, fpu_wr_dbl = 1'b0;
  logic fpu_rd_hi = 1'b0, fpu_rd_dbl = 1'b0;
  logic [4:0] vw_idx = '0, cmp_idx = '0, ld_idx = '0, fpu_wr_idx = '0;
  logic [4:0] vr_idx = '0, sl_idx = '0, st_idx = '0, fpu_rd_idx = '0;
  logic [1:0] vw_fmt = '0, cmp_fmt = '0, ld_fmt = '0;
  logic [1:0] vr_fmt = '0, sl_fmt = '0, st_fmt = '0;
  logic [3:0] vw_elem = '0, vr_elem = '0;
  logic [2:0] sl_row = '0, resp;
  logic [15:0] cmp_result = '0;
  logic [63:0] fpu_wr_data = '0, vr_elem_data, fpu_rd_data;
  logic [127:0] vw_data = '0, ld_data = '0, vr_data, sl_row_data, st_data;
  logic [127:0] m [32];
  int seed = 32'h78ee, miscompares = 0, num_checks = 0, i;
  logic be = 1'b0, en = 1'b0, us = 1'b0, wd = 1'b1;
  svr_vector_regfile i_svr_vector_regfile (.*);
  svr_core_model i_svr_core_model (.*);
  always #2 clock = ~clock;
  task automatic close_out();
    if (miscompares == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic chk(string n, logic [127:0] e, logic [127:0] g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  function automatic logic [127:0] msk(int w);
    return (128'h1 << w) - 128'h1;
  endfunction : msk
  // Memory image and register image differ only by in-element byte order
  function automatic logic [127:0] swp(logic [127:0] d, logic [1:0] f);
    logic [127:0] r;
    int b, k;
    b = 1 << f;
    for (k = 0; k < 16; k++)
      r[8*k+:8] = d[8*(be ? k - k % b + b - 1 - k % b : k)+:8];
    return r;
  endfunction : swp
  task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
    int n;
    @(posedge clock);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0)
        break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 40)
      miscompares++;
  endtask : bus
  task automatic dec();
    @(posedge clock);
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    repeat (3) @(posedge clock);
    chk("decode", (us && !wd) ? 4 : (en ? 1 : 2), resp);
  endtask : dec
  // k: 0 load, 1 element or full write, 2 compare, 3 fpu alias
  task automatic wr(int k, int ri);
    logic [127:0] d, mk;
    logic [4:0] r;
    logic [1:0] f;
    logic [3:0] e;
    int w, j;
    d = {$random(seed), $random(seed), $random(seed), $random(seed)};
    r = (ri < 0) ? 5'($random(seed)) : 5'(ri);
    f = 2'($random(seed));
    w = 8 << f;
    e = 4'($random(seed)) & 4'((16 >> f) - 1);
    mk = msk(w) << (e * w);
    @(posedge clock);
    {ld_en, vw_en, cmp_en, fpu_wr_en} <= 4'h8 >> k;
    {vw_idx, cmp_idx, ld_idx, fpu_wr_idx} <= {4{r}};
    {vw_fmt, cmp_fmt, ld_fmt} <= {3{f}};
    {vw_data, ld_data, vw_elem} <= {d, d, e};
    {cmp_result, fpu_wr_data} <= {d[15:0], d[63:0]};
    {fpu_wr_dbl, fpu_wr_hi, vw_full} <= {d[65], d[64] & !d[65], ri >= 0};
    @(posedge clock);
    {ld_en, vw_en, cmp_en, fpu_wr_en} <= 4'h0;
    case (k)
      0: m[r] = swp(d, f);
      1: m[r] = (ri < 0) ? m[r] & ~mk | (d << e * w) & mk : d;
      2:
        for (j = 0; j < 16 >> f; j++)
          m[r] = m[r] & ~(msk(w) << j * w) | {128{d[j]}} & msk(w) << j * w;
      default:
        if (d[65])
          m[r][63:0] = d[63:0];
        else if (d[64])
          m[r][63:32] = d[31:0];
        else
          m[r][31:0] = d[31:0];
    endcase
  endtask : wr
  task automatic rd();
    logic [4:0] r;
    logic [1:0] f;
    logic [3:0] e;
    logic [2:0] s;
    logic b, h;
    {r, f, b, h} = 9'($random(seed));
    e = 4'($random(seed)) & 4'((16 >> f) - 1);
    s = 3'($random(seed)) & 3'((1 << f) - 1);
    @(posedge clock);
    {vr_idx, sl_idx, st_idx, fpu_rd_idx} <= {4{r}};
    {vr_fmt, sl_fmt, st_fmt} <= {3{f}};
    {vr_elem, sl_row, fpu_rd_dbl, fpu_rd_hi} <= {e, s, b, h & !b};
    @(posedge clock);
    @(negedge clock);
    chk("vr_data", m[r], vr_data);
    chk("vr_elem_data", m[r] >> e * w_of(f) & msk(w_of(f)),
      vr_elem_data);
    chk("sl_row_data", m[r] >> s * (128 >> f) & msk(128 >> f),
      sl_row_data);
    chk("st_data", swp(m[r], f), st_data);
    chk("fpu_rd_data", b ? m[r][63:0] : h ? m[r][63:32] : m[r][31:0],
      fpu_rd_data);
  endtask : rd
  function automatic int w_of(logic [1:0] f);
    return 8 << f;
  endfunction : w_of
  initial
  begin
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    @(negedge clock);
    chk("waitrequest", 1, avs_waitrequest);
    for (i = 0; i < 2; i++)
    begin
      bus(i[0], OFS_CONFIG_WORD_THREE, '0);
      bus(1'b0, OFS_CONFIG_WORD_THREE, '0);
      chk("present", 1, q[BIT_IMPL_PRESENT]);
    end
    bus(1'b0, OFS_CONFIG_WORD_FIVE, '0);
    chk("enable", 0, q[BIT_UNIT_ENABLE]);
    bus(1'b0, 5'h14, '0);
    chk("unmapped", 0, q);
    dec();
    {us, wd} = 2'b10;
    bus(1'b1, OFS_FPU_MODE, 32'h2000_0000);
    dec();
    en = 1'b1;
    bus(1'b1, OFS_CONFIG_WORD_FIVE, 32'h0800_0000);
    dec();
    wd = 1'b1;
    bus(1'b1, OFS_FPU_MODE, 32'h2400_0000);
    dec();
    // Both sticky causes were seen; the last decode was accepted
    bus(1'b0, OFS_GATE_STATUS, '0);
    chk("gate_status", (32'h1 << BIT_SEEN_RESERVED)
      | (32'h1 << BIT_SEEN_DISABLED), q);
    bus(1'b1, OFS_GATE_STATUS, 32'hf);
    bus(1'b0, OFS_GATE_STATUS, '0);
    chk("gate_clear", 0, q);
    // Mid-run reset must drop the enable that was set above
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    {en, us, wd} = 3'b001;
    bus(1'b0, OFS_CONFIG_WORD_FIVE, '0);
    chk("enable_reset", 0, q[BIT_UNIT_ENABLE]);
    dec();
    for (i = 0; i < 32; i++)
      wr(1, i);
    repeat (2)
    begin
      bus(1'b1, OFS_CONFIG_WORD_ZERO, {16'h0, be, 15'h0});
      repeat (120)
      begin
        wr($unsigned($random(seed)) % 4, -1);
        rd();
      end
      be = !be;
    end
    close_out();
  end
  initial
  begin
    #100000;
    miscompares++;
    close_out();
  end
endmodule : testbench
